//--- rtl/an_np_pkg.sv
/*
  Shared constants for the next page exchange: register map, page word
  layout, link timing and page helpers used by both ends.
  Assumes a 250 MHz core clock on both ends and a 16-bit page word.
*/
package an_np_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int LINK_PERIOD_NS = 48;
  localparam int HALF_CYC       = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // ==========================================================
  // Register offsets of the device end
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_ADV  = 4'h1;
  localparam logic [3:0] OFF_NPTX = 4'h2;
  localparam logic [3:0] OFF_LPA  = 4'h3;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_EXP  = 4'h5;

  // ==========================================================
  // Page word fields
  localparam int BIT_NP   = 15;
  localparam int BIT_ACK  = 14;
  localparam int BIT_MP   = 13;
  localparam int BIT_ACK2 = 12;
  localparam int BIT_TGL  = 11;
  localparam int BIT_RF   = 13;
  localparam int SEL_HI   = 4;

  // Control, status and expansion bit positions
  localparam int CTRL_START = 0;
  localparam int STAT_RF    = 4;
  localparam int STAT_DONE  = 5;
  localparam int EXP_PAGE   = 1;
  localparam int EXP_LNP    = 2;
  localparam int EXP_PNP    = 3;
  localparam int EXP_PMP    = 4;
  localparam int EXP_PACK2  = 5;
  localparam int EXP_SEQERR = 6;
  localparam int EXP_PEND   = 7;

  // ==========================================================
  // Reset values and codes
  localparam logic [15:0] ADV_RST   = 16'h0001;
  localparam logic [15:0] NPTX_RST  = 16'h2001;
  localparam logic [10:0] NULL_CODE = 11'h001;
  localparam logic [10:0] MSG_LAST  = 11'h00f;

  // Null message page with NP clear
  function automatic logic [15:0] nullPage(input logic tgl, input logic ack);
    nullPage = {1'b0, ack, 1'b1, 1'b0, tgl, NULL_CODE};
  endfunction

  // True when a page carries the Null message code
  function automatic logic isNull(input logic [15:0] w);
    isNull = w[BIT_MP] && (w[10:0] == NULL_CODE);
  endfunction

  // True when a message code is a defined one
  function automatic logic msgValid(input logic [10:0] c);
    msgValid = (c != 11'h000) && (c <= MSG_LAST);
  endfunction

endpackage

//--- rtl/an_link_if.sv
/*
  Link between the device end and the partner end of the page exchange.
  Assumes the device end makes the link clock and frame; data flows both
  ways, most significant bit first, one page per frame.
*/
`timescale 1ns/1ns

interface an_link_if;
  logic linkClk;
  logic linkFrame;
  logic devData;
  logic prtData;

  modport device (
    output linkClk,
    output linkFrame,
    output devData,
    input  prtData
  );

  modport partner (
    input  linkClk,
    input  linkFrame,
    input  devData,
    output prtData
  );
endinterface

//--- rtl/an_np_partner.sv
/*
  Partner end of the page exchange: answers each frame with one page.
  Assumes the device end makes the link clock; all link inputs are
  synchronised to core_clk before use.
*/
`timescale 1ns/1ns

module an_np_partner (
  input  wire logic        core_clk,
  input  wire logic        rst,
  an_link_if.partner       link,
  input  wire logic [15:0] baseWord,
  input  wire logic [15:0] pageIn,
  input  wire logic        pageValid,
  output logic             pageTaken,
  output logic [15:0]      rxWord,
  output logic             rxValid,
  output logic             partnerDone
);

  // ==========================================================
  // Synchronisers and edge finding
  logic [2:0]  sync1_q;
  logic [2:0]  sync2_q;
  logic [2:0]  prev_q;
  logic        clkRise;
  logic        clkFall;
  logic        frmRise;
  logic        frmFall;
  logic [15:0] txSh_q;
  logic [15:0] rxSh_q;
  logic        out_q;
  logic [15:0] pend_q;
  logic        pendV_q;
  logic        baseSent_q;
  logic        npPhase_q;
  logic        myDone_q;
  logic        lpDone_q;
  logic        tgl_q;
  logic        isBase_q;
  logic        myNp_q;
  logic        take;
  logic [15:0] nextWord;

  // Two flops per link input, first flop read only by the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      prev_q  <= 3'h0;
    end else begin
      sync1_q <= {link.linkClk, link.linkFrame, link.devData};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign clkRise = sync2_q[2] && !prev_q[2] && sync2_q[1];
  assign clkFall = !sync2_q[2] && prev_q[2] && sync2_q[1];
  assign frmRise = sync2_q[1] && !prev_q[1];
  assign frmFall = !sync2_q[1] && prev_q[1];

  // ==========================================================
  // Page choice at frame start
  always_comb begin
    take     = 1'b0;
    nextWord = an_np_pkg::nullPage(!tgl_q, 1'b1);
    if (!baseSent_q) begin
      nextWord = baseWord;
    end else if (pendV_q && !myDone_q) begin
      take     = 1'b1;
      nextWord = pend_q;
      nextWord[an_np_pkg::BIT_TGL] = !tgl_q;    // [R9]
      nextWord[an_np_pkg::BIT_ACK] = 1'b1;
    end                                     // [R12] Null when nothing to send
  end

  // Pending page from the user side
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q    <= 16'h0000;
      pendV_q   <= 1'b0;
      pageTaken <= 1'b0;
    end else begin
      pageTaken <= frmRise && take;
      if (frmRise && take) begin
        pendV_q <= 1'b0;
      end else if (pageValid && !pendV_q) begin
        pend_q  <= pageIn;
        pendV_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Shift both directions
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txSh_q <= 16'h0000;
      rxSh_q <= 16'h0000;
      out_q  <= 1'b0;
    end else if (frmRise) begin
      out_q  <= nextWord[15];
      txSh_q <= {nextWord[14:0], 1'b0};
    end else if (clkFall) begin
      out_q  <= txSh_q[15];
      txSh_q <= {txSh_q[14:0], 1'b0};
    end else if (clkRise) begin
      rxSh_q <= {rxSh_q[14:0], sync2_q[0]};
    end
  end

  assign link.prtData = out_q;

  // ==========================================================
  // Exchange sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      baseSent_q  <= 1'b0;
      npPhase_q   <= 1'b0;
      myDone_q    <= 1'b0;
      lpDone_q    <= 1'b0;
      tgl_q       <= 1'b0;
      isBase_q    <= 1'b0;
      myNp_q      <= 1'b0;
      rxWord      <= 16'h0000;
      rxValid     <= 1'b0;
      partnerDone <= 1'b0;
    end else begin
      rxValid <= frmFall;
      if (frmRise) begin
        isBase_q   <= !baseSent_q;
        baseSent_q <= 1'b1;
        tgl_q      <= nextWord[an_np_pkg::BIT_TGL];
        myNp_q     <= nextWord[an_np_pkg::BIT_NP];
        if (baseSent_q && !nextWord[an_np_pkg::BIT_NP]) begin
          myDone_q <= 1'b1;                 // [R6]
        end
      end
      if (frmFall) begin
        rxWord <= rxSh_q;
        if (isBase_q) begin
          npPhase_q   <= myNp_q && rxSh_q[an_np_pkg::BIT_NP];      // [R11]
          partnerDone <= !(myNp_q && rxSh_q[an_np_pkg::BIT_NP]);
          baseSent_q  <= myNp_q && rxSh_q[an_np_pkg::BIT_NP];
          myDone_q    <= 1'b0;
          lpDone_q    <= 1'b0;
        end else if (npPhase_q) begin
          if (myDone_q && (lpDone_q || !rxSh_q[an_np_pkg::BIT_NP]
                           || an_np_pkg::isNull(rxSh_q))) begin
            partnerDone <= 1'b1;            // [R12]
            npPhase_q   <= 1'b0;
            baseSent_q  <= 1'b0;
          end
          if (!rxSh_q[an_np_pkg::BIT_NP] || an_np_pkg::isNull(rxSh_q)) begin
            lpDone_q <= 1'b1;               // [R4]
          end
        end
      end
      if (frmRise && !baseSent_q) begin
        partnerDone <= 1'b0;
      end
    end
  end

endmodule

//--- rtl/an_np_device.sv
/*
  Device end of the next page exchange with remote fault handling.
  Software reaches the registers over a plain port with read data one
  cycle after the read strobe. Assumes the partner answers every frame.
*/
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ns

// Function
// [R1] Unformatted runs follow a Message Page
// [R2] Matching selectors: selector governs page use
// [R3] Send Null NP=0 while partner continues
// [R4] Received Null ends partner's pages
// [R5] Code field meaning follows MP
// [R6] NP=0 marks last page
// [R7] MP selects Message or Unformatted page
// [R8] Ack2 reports compliance with message
// [R9] Toggle inverts previous transmitted toggle
// [R10] Never transmit undefined message codes
// [R11] Both Next Page able: one page minimum
// [R12] Exchange until neither end has more
// [R13] Unformatted pages immediately follow their message
// [R14] Received pages stored for management
// [R15] Transmitted fault bit from advertisement bit
// [R16] Fault bit held until base renegotiation
// [R17] Received fault sets status fault bit
// [R18] Status fault held until read or reset
// [R19] Page received set; cleared on read
// [R20] Word layout NP Ack MP Ack2 T code
// [R21] Load page only after management write
// [R22] Null is message code one, MP=1
module an_np_device (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wrData,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  output logic [15:0]      rdData,
  output logic             anDone,
  an_link_if.device        link
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_BASE  = 5'b00010,
    ST_WAIT  = 5'b00100,
    ST_XFER  = 5'b01000,
    ST_DONE  = 5'b10000
  } state_e;

  state_e      state_q;
  logic [15:0] adv_q;
  logic [15:0] nptx_q;
  logic        npPend_q;
  logic [15:0] lpa_q;
  logic [4:0]  lpSel_q;
  logic        rfStat_q;
  logic        pageRx_q;
  logic        lpNp_q;
  logic        seqErr_q;
  logic        rfTx_q;
  logic        txTgl_q;
  logic        msgSeen_q;
  logic        localDone_q;
  logic        prtDone_q;
  logic        startReq;
  logic        sendNp;
  logic        seqBad;
  logic        selMatch;
  logic [15:0] npWord;
  logic        pd1_q;
  logic        pd2_q;
  logic        xfer_q;
  logic        clk_q;
  logic        frame_q;
  logic        data_q;
  logic [4:0]  bitCnt_q;
  logic [2:0]  div_q;
  logic [15:0] txSh_q;
  logic [15:0] rxSh_q;
  logic        xDone_q;
  logic        startX;
  logic [15:0] txWord;
  logic        tick;

  // ==========================================================
  // Register port
  assign startReq = wrEn && (addr == an_np_pkg::OFF_CTRL) && wrData[an_np_pkg::CTRL_START];

  // Writable registers; a pending page waits for software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      adv_q    <= an_np_pkg::ADV_RST;
      nptx_q   <= an_np_pkg::NPTX_RST;
      npPend_q <= 1'b0;
    end else begin
      if (wrEn && addr == an_np_pkg::OFF_ADV) begin
        adv_q <= wrData;
      end
      if (wrEn && addr == an_np_pkg::OFF_NPTX) begin
        nptx_q   <= wrData;
        npPend_q <= 1'b1;                    // [R21]
      end else if (sendNp) begin
        npPend_q <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData <= 16'h0000;
    end else if (rdEn) begin
      case (addr)
        an_np_pkg::OFF_ADV:  rdData <= adv_q;
        an_np_pkg::OFF_NPTX: rdData <= nptx_q;
        an_np_pkg::OFF_LPA:  rdData <= lpa_q;          // [R14]
        an_np_pkg::OFF_STAT: rdData <= {10'h000, anDone, rfStat_q, 4'h0};
        an_np_pkg::OFF_EXP:  rdData <= {8'h00, npPend_q, seqErr_q,
                                        lpa_q[an_np_pkg::BIT_ACK2],   // [R8]
                                        lpa_q[an_np_pkg::BIT_MP],     // [R5] [R7]
                                        lpNp_q, adv_q[an_np_pkg::BIT_NP],
                                        pageRx_q, 1'b0};
        default:             rdData <= 16'h0000;
      endcase
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rfStat_q <= 1'b0;
      pageRx_q <= 1'b0;
    end else begin
      if (xDone_q && state_q == ST_BASE && rxSh_q[an_np_pkg::BIT_RF]) begin
        rfStat_q <= 1'b1;                    // [R17]
      end else if (rdEn && addr == an_np_pkg::OFF_STAT) begin
        rfStat_q <= 1'b0;                    // [R18]
      end
      if (xDone_q) begin
        pageRx_q <= 1'b1;                    // [R19]
      end else if (rdEn && addr == an_np_pkg::OFF_EXP) begin
        pageRx_q <= 1'b0;                    // [R19]
      end
    end
  end

  // ==========================================================
  // Outgoing page build
  // Partner selector kept from its base page, later pages overwrite lpa_q
  assign selMatch = adv_q[an_np_pkg::SEL_HI:0] == lpSel_q;  // [R2]

  always_comb begin
    sendNp = 1'b0;
    seqBad = 1'b0;
    npWord = an_np_pkg::nullPage(!txTgl_q, 1'b1);   // [R3] [R22]
    if (state_q == ST_WAIT && !xfer_q && !localDone_q && npPend_q) begin
      sendNp = 1'b1;
      npWord = nptx_q;                              // [R20]
      npWord[an_np_pkg::BIT_ACK] = 1'b1;
      npWord[an_np_pkg::BIT_TGL] = !txTgl_q;        // [R9]
      // Unformatted without a preceding message, unless selector rules
      seqBad = !nptx_q[an_np_pkg::BIT_MP] && !msgSeen_q && !selMatch;  // [R1] [R2] [R13]
      if ((nptx_q[an_np_pkg::BIT_MP] && !an_np_pkg::msgValid(nptx_q[10:0])) || seqBad) begin
        npWord = an_np_pkg::nullPage(!txTgl_q, 1'b1);  // [R10]
      end
    end
  end

  assign startX = (state_q == ST_IDLE && startReq)
               || (state_q == ST_WAIT && !xfer_q && (localDone_q || npPend_q));
  assign txWord = (state_q == ST_IDLE)
                ? {adv_q[15:14], adv_q[an_np_pkg::BIT_RF] | rfTx_q, adv_q[12:0]}  // [R15]
                : npWord;

  // ==========================================================
  // Negotiation sequence
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      lpa_q       <= 16'h0000;
      lpSel_q     <= 5'h00;
      lpNp_q      <= 1'b0;
      seqErr_q    <= 1'b0;
      txTgl_q     <= 1'b0;
      msgSeen_q   <= 1'b0;
      localDone_q <= 1'b0;
      prtDone_q   <= 1'b0;
      anDone      <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (startReq) begin
            anDone      <= 1'b0;
            txTgl_q     <= txWord[an_np_pkg::BIT_TGL];
            msgSeen_q   <= 1'b0;
            localDone_q <= 1'b0;
            prtDone_q   <= 1'b0;
            state_q     <= ST_BASE;
          end
        end
        ST_BASE: begin
          if (xDone_q) begin
            lpa_q   <= rxSh_q;
            lpSel_q <= rxSh_q[an_np_pkg::SEL_HI:0];
            lpNp_q  <= rxSh_q[an_np_pkg::BIT_NP];
            if (adv_q[an_np_pkg::BIT_NP] && rxSh_q[an_np_pkg::BIT_NP]) begin
              state_q <= ST_WAIT;            // [R11]
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_WAIT: begin
          if (startX) begin
            txTgl_q <= npWord[an_np_pkg::BIT_TGL];
            if (seqBad) begin
              seqErr_q <= 1'b1;
            end
            if (npWord[an_np_pkg::BIT_MP]) begin
              msgSeen_q <= 1'b1;
            end
            if (!npWord[an_np_pkg::BIT_NP]) begin
              localDone_q <= 1'b1;           // [R6]
            end
            state_q <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (xDone_q) begin
            lpa_q <= rxSh_q;                 // [R14]
            if (localDone_q && (prtDone_q || !rxSh_q[an_np_pkg::BIT_NP]
                                || an_np_pkg::isNull(rxSh_q))) begin
              state_q <= ST_DONE;            // [R12]
            end else begin
              state_q <= ST_WAIT;            // [R3]
            end
            if (!rxSh_q[an_np_pkg::BIT_NP] || an_np_pkg::isNull(rxSh_q)) begin
              prtDone_q <= 1'b1;             // [R4]
            end
          end
        end
        ST_DONE: begin
          anDone  <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Transmitted fault bit latched until a base renegotiation completes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rfTx_q <= 1'b0;
    end else if (adv_q[an_np_pkg::BIT_RF]) begin
      rfTx_q <= 1'b1;                        // [R16]
    end else if (state_q == ST_DONE) begin
      rfTx_q <= 1'b0;                        // [R16]
    end
  end

  // ==========================================================
  // Link engine: divided clock, framed 16-bit full duplex shift
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pd1_q <= 1'b0;
      pd2_q <= 1'b0;
    end else begin
      pd1_q <= link.prtData;
      pd2_q <= pd1_q;
    end
  end

  assign tick = xfer_q && (div_q == 3'(an_np_pkg::HALF_CYC - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xfer_q   <= 1'b0;
      clk_q    <= 1'b0;
      frame_q  <= 1'b0;
      data_q   <= 1'b0;
      bitCnt_q <= 5'h00;
      div_q    <= 3'h0;
      txSh_q   <= 16'h0000;
      rxSh_q   <= 16'h0000;
      xDone_q  <= 1'b0;
    end else begin
      xDone_q <= tick && !clk_q && bitCnt_q == 5'h10;
      if (startX) begin
        xfer_q   <= 1'b1;
        frame_q  <= 1'b1;
        clk_q    <= 1'b0;
        data_q   <= txWord[15];
        txSh_q   <= {txWord[14:0], 1'b0};
        bitCnt_q <= 5'h00;
        div_q    <= 3'h0;
      end else if (xfer_q) begin
        div_q <= tick ? 3'h0 : div_q + 3'h1;
        if (tick && !clk_q) begin
          // Tail half period lets the partner see the frame drop
          if (bitCnt_q == 5'h10) begin
            xfer_q <= 1'b0;
          end else begin
            clk_q <= 1'b1;
          end
        end else if (tick) begin
          clk_q    <= 1'b0;
          rxSh_q   <= {rxSh_q[14:0], pd2_q};
          bitCnt_q <= bitCnt_q + 5'h01;
          data_q   <= txSh_q[15];
          txSh_q   <= {txSh_q[14:0], 1'b0};
          if (bitCnt_q == 5'h0f) begin
            frame_q <= 1'b0;
            data_q  <= 1'b0;
          end
        end
      end
    end
  end

  assign link.linkClk   = clk_q;
  assign link.linkFrame = frame_q;
  assign link.devData   = data_q;

endmodule

//--- dv/an_np_sva.sv
/*
  Wire checks for the link between the two ends of the page exchange.
  Assumes it is instantiated beside the interface and sees its signals.
*/
`timescale 1ns/1ns

module an_np_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic linkFrame,
  input wire logic devData,
  input wire logic prtData
);
  // ==========================================================
  // Helper logic
  logic [7:0] frameCnt_q;

  // Counts core cycles of the frame in progress
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frameCnt_q <= 8'h00;
    end else if (!linkFrame) begin
      frameCnt_q <= 8'h00;
    end else begin
      frameCnt_q <= frameCnt_q + 8'h01;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_CLK_IDLE: assert property (!linkFrame |-> !linkClk)
    else $error("link clock moves outside a frame");
  AST_FIRST_LOW: assert property ($rose(linkFrame) |-> !linkClk [*6] ##1 linkClk)
    else $error("first link clock half is not six cycles low");
  AST_HIGH_SIX: assert property (linkFrame && $rose(linkClk) |-> linkClk [*6] ##1 !linkClk)
    else $error("link clock high half is not six cycles");
  AST_LOW_SIX: assert property (linkFrame && $fell(linkClk) |-> !linkClk [*6] ##1 linkClk)
    else $error("link clock low half is not six cycles");
  AST_FRAME_LEN: assert property ($fell(linkFrame) |-> frameCnt_q == 8'hc0)
    else $error("frame is not sixteen bits long");
  AST_GAP: assert property ($fell(linkFrame) |-> !linkFrame [*6])
    else $error("frames closer than the tail");
  AST_DEV_STABLE: assert property (linkFrame && linkClk |-> $stable(devData))
    else $error("device bit changes while link clock high");
  AST_DEV_EDGE: assert property (linkFrame && !$rose(linkFrame) && $changed(devData)
    |-> $fell(linkClk))
    else $error("device bit changes away from a clock fall");
  AST_PRT_STABLE: assert property (linkFrame && linkClk |-> $stable(prtData))
    else $error("partner bit changes while link clock high");
  AST_TAIL_ZERO: assert property ($fell(linkFrame) |-> !devData)
    else $error("device bit not low after frame");

  // Main scenarios
  COV_FRAME: cover property ($fell(linkFrame) && frameCnt_q == 8'hc0);
  COV_PRT_ONE: cover property (linkFrame && prtData);
  COV_BACK: cover property ($fell(linkFrame) ##[6:40] $rose(linkFrame));
endmodule

//--- dv/tb_top.sv
/*
  Testbench: both ends joined by the link, driven from their user sides.
  Assumes the register port and partner user port of the design ends.
*/
`timescale 1ns/1ns

module tb_top;
  // ==========================================================
  // Signals
  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic [3:0]  addr      = 4'h0;
  logic [15:0] wrData    = 16'h0000;
  logic        wrEn      = 1'b0;
  logic        rdEn      = 1'b0;
  logic [15:0] baseWord  = 16'h0000;
  logic [15:0] pageIn    = 16'h0000;
  logic        pageValid = 1'b0;
  logic [15:0] rdData;
  logic        anDone;
  logic        pageTaken;
  logic [15:0] rxWord;
  logic        rxValid;
  logic        partnerDone;
  logic [15:0] devPg [3];
  logic [15:0] prtPg [3];
  logic [15:0] rv;
  logic [15:0] adv;
  logic [31:0] r;
  logic [31:0] seed = 32'h0000_7b6b;
  logic        lone = 1'b0;
  int          num_errors = 0;
  int          n_checks = 0;

  an_link_if an_link_if_inst ();
  an_np_device an_np_device_inst (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .anDone(anDone),
    .link(an_link_if_inst.device));
  an_np_partner an_np_partner_inst (.core_clk(core_clk), .rst(rst),
    .link(an_link_if_inst.partner), .baseWord(baseWord), .pageIn(pageIn),
    .pageValid(pageValid), .pageTaken(pageTaken), .rxWord(rxWord), .rxValid(rxValid),
    .partnerDone(partnerDone));
  an_np_sva an_np_sva_inst (.core_clk(core_clk), .rst(rst),
    .linkClk(an_link_if_inst.linkClk), .linkFrame(an_link_if_inst.linkFrame),
    .devData(an_link_if_inst.devData), .prtData(an_link_if_inst.prtData));

  // Core clock
  always #2 core_clk = ~core_clk;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Page the device should send: undefined codes, lone unformatted and idle turns give Null
  function automatic logic [15:0] expTx(input logic [15:0] w, input logic t, input logic own);
    if (!own || (lone && !w[13]) || (w[13] && (w[10:0] == 11'h000 || w[10:0] > 11'h00f))) begin
      return {4'b0110, t, 11'h001};
    end
    return {w[15], 1'b1, w[13:12], t, w[10:0]};
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chkW(input string name, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chkB(input string name, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge core_clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge core_clk);
    rdEn <= 1'b0;
    @(negedge core_clk);
    d = rdData;
  endtask

  task automatic offer(input logic [15:0] w);
    @(posedge core_clk);
    pageIn <= w;
    pageValid <= 1'b1;
    @(posedge core_clk);
    pageValid <= 1'b0;
  endtask

  task automatic waitFor(input bit rx);
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if ((rx ? rxValid : pageTaken) === 1'b1) return;
    end
    num_errors++;
    $display("ERROR wait timed out");
    give_verdict();
  endtask

  // One negotiation: base page, then n next pages, device owning nDev
  task automatic negotiate(input logic [15:0] a, input logic rfExp, input int nDev,
                           input int n);
    logic t;
    t = ~a[11];
    wr(an_np_pkg::OFF_ADV, a);
    wr(an_np_pkg::OFF_CTRL, 16'h0001);
    waitFor(1'b1);
    chkW("baseTx", {a[15], 1'b0, rfExp, a[12:0]}, rxWord & 16'hbfff);
    repeat (16) @(posedge core_clk);
    rd(an_np_pkg::OFF_STAT, rv);
    chkB("rfStat", 1'b1, rv[an_np_pkg::STAT_RF]);
    rd(an_np_pkg::OFF_STAT, rv);
    chkB("rfStatClr", 1'b0, rv[an_np_pkg::STAT_RF]);
    rd(an_np_pkg::OFF_EXP, rv);
    chkB("pageRx", 1'b1, rv[an_np_pkg::EXP_PAGE]);
    rd(an_np_pkg::OFF_EXP, rv);
    chkB("pageRxClr", 1'b0, rv[an_np_pkg::EXP_PAGE]);
    rd(an_np_pkg::OFF_LPA, rv);
    chkW("lpaBase", baseWord, rv);
    for (int k = 0; k < n; k++) begin
      if (k == 0) offer(prtPg[0]);
      if (k < nDev) wr(an_np_pkg::OFF_NPTX, devPg[k]);
      if (k < n - 1) begin
        waitFor(1'b0);
        offer(prtPg[k + 1]);
      end
      waitFor(1'b1);
      chkW("npTx", expTx(devPg[k], t, k < nDev), rxWord);
      t = ~t;
      repeat (24) @(posedge core_clk);
      rd(an_np_pkg::OFF_LPA, rv);
      chkW("lpaNp", prtPg[k], rv);
      if (k < n - 1) chkB("doneEarly", 1'b0, anDone);
      if (k < n - 1) chkB("prtEarly", 1'b0, partnerDone);
    end
    chkB("anDone", 1'b1, anDone);
    chkB("prtDone", 1'b1, partnerDone);
    repeat (64) @(posedge core_clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(an_np_pkg::OFF_ADV, rv);
    chkW("advRst", an_np_pkg::ADV_RST, rv);
    rd(an_np_pkg::OFF_NPTX, rv);
    chkW("nptxRst", an_np_pkg::NPTX_RST, rv);
    rd(4'hf, rv);
    chkW("unmapped", 16'h0000, rv);
    @(posedge core_clk);
    r = rnd();
    baseWord <= 16'ha002;
    adv = {3'b101, r[7:0], 5'h01};
    r = rnd();
    devPg[0] = {3'b101, r[8], 1'b0, 7'h00, r[3:0] | 4'h2};
    devPg[1] = {3'b000, r[9], 1'b0, r[20:10]};
    devPg[2] = 16'h0000;
    prtPg[0] = {5'b11101, 11'h005};
    prtPg[1] = {5'b11000, r[31:21]};
    prtPg[2] = {3'b011, r[5], 12'h801};
    negotiate(adv, 1'b1, 2, 3);
    rd(an_np_pkg::OFF_EXP, rv);
    chkB("seqErr", 1'b0, rv[an_np_pkg::EXP_SEQERR]);
    chkB("lpMp", prtPg[2][13], rv[an_np_pkg::EXP_PMP]);
    chkB("lpAck2", prtPg[2][12], rv[an_np_pkg::EXP_PACK2]);
    devPg[0] = 16'ha7ff;
    prtPg[0] = 16'h6801;
    negotiate({adv[15:14], 1'b0, adv[12:0]}, 1'b1, 1, 1);
    // Lone unformatted page: Null when selectors differ, sent as is when they match
    devPg[0] = {5'h00, r[30:20]};
    lone = 1'b1;
    negotiate({adv[15:14], 1'b0, adv[12:0]}, 1'b0, 1, 1);
    rd(an_np_pkg::OFF_EXP, rv);
    chkB("seqErrSet", 1'b1, rv[an_np_pkg::EXP_SEQERR]);
    lone = 1'b0;
    negotiate({adv[15:14], 1'b0, adv[12:5], baseWord[4:0]}, 1'b0, 1, 1);
    give_verdict();
  end
endmodule
